/* hw/hub_ctrl_pkg.sv */
// Package of constants and types for the hub port power and charge control
package hub_ctrl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS = 4;

  // ----------------------------------------------------------------
  // Upstream speed encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UP_SPEED_SUPER = 2'h0,
    UP_SPEED_HIGH  = 2'h1,
    UP_SPEED_FULL  = 2'h2
  } up_speed_e;

  // ----------------------------------------------------------------
  // Charge mode encoding per port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CHG_OFF                    = 3'h0,
    host_charge_handshake_mode = 3'h1,
    dedicated_charger_mode     = 3'h2,
    divider_charge_mode_first  = 3'h3,
    divider_charge_mode_second = 3'h4,
    divider_charge_mode_third  = 3'h5
  } charge_mode_e;

  // Requested charge policy while upstream is unconnected
  typedef enum logic [2:0] {
    POL_DEDICATED = 3'h0,
    POL_DIV_FIRST = 3'h1,
    POL_DIV_SECOND = 3'h2,
    POL_DIV_THIRD = 3'h3,
    POL_AUTO      = 3'h4
  } charge_policy_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned AUTO_STEP_US     = 1000;
  localparam int unsigned AUTO_STEP_CYCLES = (AUTO_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam logic [2:0]  STRAP_SETTLE     = 3'h4;  // Wait count after release; straps latch on the next edge, the fifth

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0] RST_POWER  = 4'h0;
  localparam logic [NUM_PORTS-1:0] RST_CHARGE = 4'h0;

endpackage : hub_ctrl_pkg

/* hw/hub_sync_if.sv */
// Interface carrying synchronised pin levels between design modules
`timescale 1ns/1ps
interface hub_sync_if #(
  parameter int unsigned WIDTH = 4
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;

  modport sync_side (input raw, output level);
  modport user_side (output raw, input level);
endinterface : hub_sync_if

/* hw/hub_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hub_pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  hub_sync_if.sync_side   bus
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] next_held;

  // Accept a change once second and third stages agree
  always_comb begin
    next_held = held;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_held[i] = stage3[i];
      end
    end
  end

  // Register the stages
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      held   <= '0;
    end else begin
      stage1 <= bus.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      held   <= next_held;
    end
  end

  assign bus.level = held;

endmodule : hub_pin_sync

/* hw/hub_port_power_charge_ctrl.sv */
// Per-port speed, power switching and charge mode control of a four-port hub
`timescale 1ns/1ps

module hub_port_power_charge_ctrl #(
  parameter int unsigned STEP_CYCLES = hub_ctrl_pkg::AUTO_STEP_CYCLES
) (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_resetn,
  input  wire logic                                  i_ganged,
  input  wire hub_ctrl_pkg::up_speed_e               i_up_speed,
  input  wire logic                                  i_up_connected,
  input  wire logic                                  i_up_configured,
  input  wire logic [hub_ctrl_pkg::NUM_PORTS-1:0]    i_power_request,
  input  wire logic [hub_ctrl_pkg::NUM_PORTS-1:0]    i_removal_ok,
  input  wire logic [hub_ctrl_pkg::NUM_PORTS-1:0]    i_overcurrent_n,
  input  wire logic [hub_ctrl_pkg::NUM_PORTS-1:0]    i_usb2_only,
  input  wire logic [hub_ctrl_pkg::NUM_PORTS-1:0]    i_power_charge_strap,
  input  wire hub_ctrl_pkg::charge_policy_e          i_charge_policy,
  output logic      [hub_ctrl_pkg::NUM_PORTS-1:0]    o_port_power,
  output logic      [hub_ctrl_pkg::NUM_PORTS-1:0]    o_port_power_oe,
  output logic      [hub_ctrl_pkg::NUM_PORTS-1:0]    o_super_enable,
  output logic      [hub_ctrl_pkg::NUM_PORTS-1:0]    o_high_enable,
  output logic      [hub_ctrl_pkg::NUM_PORTS-1:0]    o_charge_supported,
  output hub_ctrl_pkg::charge_mode_e                 o_charge_mode [hub_ctrl_pkg::NUM_PORTS]
);
  import hub_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hub_sync_if #(.WIDTH(NUM_PORTS)) oc_bus ();
  hub_sync_if #(.WIDTH(NUM_PORTS)) strap_bus ();

  assign oc_bus.raw    = ~i_overcurrent_n;
  assign strap_bus.raw = i_power_charge_strap;

  hub_pin_sync #(.WIDTH(NUM_PORTS)) u_oc_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (oc_bus.sync_side)
  );

  hub_pin_sync #(.WIDTH(NUM_PORTS)) u_strap_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (strap_bus.sync_side)
  );

  logic [NUM_PORTS-1:0] oc_level;
  assign oc_level = oc_bus.level;

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  logic [2:0]           strap_wait;
  logic [2:0]           next_strap_wait;
  logic                 strap_done;
  logic                 next_strap_done;
  logic [NUM_PORTS-1:0] next_charge_supported;

  // Wait for the synchroniser to fill, then latch the straps once
  always_comb begin
    next_strap_wait       = strap_wait;
    next_strap_done       = strap_done;
    next_charge_supported = o_charge_supported;
    if (!strap_done) begin
      if (strap_wait == STRAP_SETTLE) begin
        next_strap_done       = 1'b1;
        next_charge_supported = strap_bus.level;
      end else begin
        next_strap_wait = strap_wait + 3'h1;
      end
    end
  end

  // Register the strap capture state
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      strap_wait         <= 3'h0;
      strap_done         <= 1'b0;
      o_charge_supported <= RST_CHARGE;
    end else begin
      strap_wait         <= next_strap_wait;
      strap_done         <= next_strap_done;
      o_charge_supported <= next_charge_supported;
    end
  end

  // ----------------------------------------------------------------
  // Shared strap pin drive
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] next_port_power_oe;

  // Keep the strap pins released until the straps are latched
  always_comb begin
    next_port_power_oe = {NUM_PORTS{next_strap_done}};
  end

  // Register the pin drive enable
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_port_power_oe <= '0;
    end else begin
      o_port_power_oe <= next_port_power_oe;
    end
  end

  // ----------------------------------------------------------------
  // Power switching
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] power_state;
  logic [NUM_PORTS-1:0] next_power_state;
  logic                 ganged_on;
  logic                 next_ganged_on;

  // Individual or ganged power decision with overcurrent cut
  always_comb begin
    next_power_state = power_state;
    next_ganged_on   = ganged_on;
    if (!strap_done) begin
      next_power_state = '0;
      next_ganged_on   = 1'b0;
    end else if (i_ganged) begin
      if (|oc_level) begin
        next_ganged_on = 1'b0;
      end else if (|i_power_request) begin
        next_ganged_on = 1'b1;
      end else if (&i_removal_ok) begin
        next_ganged_on = 1'b0;
      end
      next_power_state = {NUM_PORTS{next_ganged_on}};
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (oc_level[i]) begin
          next_power_state[i] = 1'b0;
        end else begin
          next_power_state[i] = i_power_request[i];
        end
      end
      next_ganged_on = |next_power_state;                            // Powered ports stay on into ganged
    end
  end

  // Register the power decision
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      power_state  <= RST_POWER;
      ganged_on    <= 1'b0;
      o_port_power <= RST_POWER;
    end else begin
      power_state  <= next_power_state;
      ganged_on    <= next_ganged_on;
      o_port_power <= next_power_state;
    end
  end

  // ----------------------------------------------------------------
  // Speed enables
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] next_super_enable;
  logic [NUM_PORTS-1:0] next_high_enable;
  logic                 up_allows_super;
  logic                 up_allows_high;

  // Upstream capability decode shared by all ports
  assign up_allows_super = (i_up_speed == UP_SPEED_SUPER);
  assign up_allows_high  = (i_up_speed != UP_SPEED_FULL);

  // Limit downstream speed to what upstream and port config allow
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_super_enable[i] = strap_done && up_allows_super
                             && !i_usb2_only[i];
      next_high_enable[i]  = strap_done && up_allows_high;
    end
  end

  // Register the speed enables
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_super_enable <= '0;
      o_high_enable  <= '0;
    end else begin
      o_super_enable <= next_super_enable;
      o_high_enable  <= next_high_enable;
    end
  end

  // ----------------------------------------------------------------
  // Automatic charge sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AUTO_THIRD,
    AUTO_SECOND,
    AUTO_FIRST,
    AUTO_DEDICATED
  } auto_state_e;

  auto_state_e auto_state;
  auto_state_e next_auto_state;
  logic [31:0] step_count;
  logic [31:0] next_step_count;
  logic        auto_run;

  assign auto_run = strap_done && !i_up_connected && (i_charge_policy == POL_AUTO);

  // Step third, second, first divider, then stay in dedicated
  always_comb begin
    next_auto_state = auto_state;
    next_step_count = step_count;
    if (!auto_run) begin
      next_auto_state = AUTO_THIRD;
      next_step_count = '0;
    end else if (auto_state != AUTO_DEDICATED) begin
      if (step_count == STEP_CYCLES - 1) begin
        next_step_count = '0;
        case (auto_state)
          AUTO_THIRD:  next_auto_state = AUTO_SECOND;
          AUTO_SECOND: next_auto_state = AUTO_FIRST;
          AUTO_FIRST:  next_auto_state = AUTO_DEDICATED;
          default:     next_auto_state = AUTO_DEDICATED;
        endcase
      end else begin
        next_step_count = step_count + 32'h1;
      end
    end
  end

  // Register the sequencer state and step counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      auto_state <= AUTO_THIRD;
      step_count <= '0;
    end else begin
      auto_state <= next_auto_state;
      step_count <= next_step_count;
    end
  end

  // ----------------------------------------------------------------
  // Charge mode per port
  // ----------------------------------------------------------------
  charge_mode_e unconn_mode;
  charge_mode_e next_charge_mode [NUM_PORTS];
  logic         divider_allowed;

  assign divider_allowed = !i_up_connected || !i_up_configured;

  // Mode chosen for an unconnected upstream
  always_comb begin
    case (i_charge_policy)
      POL_DIV_FIRST:  unconn_mode = divider_charge_mode_first;
      POL_DIV_SECOND: unconn_mode = divider_charge_mode_second;
      POL_DIV_THIRD:  unconn_mode = divider_charge_mode_third;
      POL_AUTO: begin
        case (auto_state)
          AUTO_THIRD:  unconn_mode = divider_charge_mode_third;
          AUTO_SECOND: unconn_mode = divider_charge_mode_second;
          AUTO_FIRST:  unconn_mode = divider_charge_mode_first;
          default:     unconn_mode = dedicated_charger_mode;
        endcase
      end
      default:        unconn_mode = dedicated_charger_mode;
    endcase
  end

  // Handshake mode when connected, policy mode otherwise
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!strap_done || !o_charge_supported[i]) begin
        next_charge_mode[i] = CHG_OFF;
      end else if (i_up_connected) begin
        next_charge_mode[i] = host_charge_handshake_mode;
      end else if (divider_allowed) begin
        next_charge_mode[i] = unconn_mode;
      end else begin
        next_charge_mode[i] = dedicated_charger_mode;
      end
    end
  end

  // Register the per-port charge modes
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!i_resetn) begin
        o_charge_mode[i] <= CHG_OFF;
      end else begin
        o_charge_mode[i] <= next_charge_mode[i];
      end
    end
  end

endmodule : hub_port_power_charge_ctrl

/* verification/hub_ctrl_asserts.sv */
// Checker of port power, speed and charge outputs
`timescale 1ns/1ps
module hub_ctrl_asserts #(
  parameter int unsigned STEP_CYCLES = 8
) (
  input wire logic                               i_clk,
  input wire logic                               i_resetn,
  input wire logic                               i_ganged,
  input wire hub_ctrl_pkg::up_speed_e            i_up_speed,
  input wire logic                               i_up_connected,
  input wire logic                               i_up_configured,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] i_power_request,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] i_removal_ok,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] i_overcurrent_n,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] i_usb2_only,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] i_power_charge_strap,
  input wire hub_ctrl_pkg::charge_policy_e       i_charge_policy,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] o_port_power,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] o_port_power_oe,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] o_super_enable,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] o_high_enable,
  input wire logic [hub_ctrl_pkg::NUM_PORTS-1:0] o_charge_supported,
  input wire hub_ctrl_pkg::charge_mode_e         o_charge_mode [hub_ctrl_pkg::NUM_PORTS]
);
  import hub_ctrl_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Overcurrent levels held long enough to cross the synchroniser
  sequence s_oc_any_ganged;   (i_ganged && i_overcurrent_n != 4'hf)[*6]; endsequence
  sequence s_oc_clear_ganged; (i_ganged && i_overcurrent_n == 4'hf)[*6]; endsequence
  sequence s_oc_port0_indiv;  (!i_ganged && !i_overcurrent_n[0])[*6]; endsequence
  sequence s_indiv_settled;   (!i_ganged && i_overcurrent_n == 4'hf && o_port_power_oe == 4'hf)[*6]; endsequence
  a_super_off_slow: assert property (i_up_speed != UP_SPEED_SUPER |=> o_super_enable == 4'h0)
    else $error("super enable with slow upstream");
  a_high_off_full: assert property (i_up_speed == UP_SPEED_FULL |=> o_high_enable == 4'h0)
    else $error("high enable with full speed upstream");
  a_usb2_no_super: assert property (1'b1 |=> (o_super_enable & $past(i_usb2_only)) == 4'h0)
    else $error("super enable on usb2 only port");
  a_indiv_follow: assert property (s_indiv_settled |=> o_port_power == $past(i_power_request))
    else $error("individual power not following request");
  a_indiv_oc_one: assert property (s_oc_port0_indiv |=> !o_port_power[0])
    else $error("port power on during its overcurrent");
  a_ganged_all_on: assert property (s_oc_clear_ganged ##0 (|i_power_request && o_port_power_oe[0])
    |=> o_port_power == 4'hf)
    else $error("ganged power not on for all ports");
  a_ganged_hold: assert property (s_oc_clear_ganged ##0 (o_port_power == 4'hf && i_removal_ok != 4'hf)
    |=> o_port_power == 4'hf)
    else $error("ganged power removed too early");
  a_ganged_oc_all: assert property (s_oc_any_ganged |=> o_port_power == 4'h0)
    else $error("ganged power on during overcurrent");
  a_conn_handshake: assert property (i_up_connected && o_charge_supported[0]
    |=> o_charge_mode[0] == host_charge_handshake_mode)
    else $error("connected port not in handshake mode");
  a_strap_off: assert property ((o_charge_supported[0] || o_charge_mode[0] == CHG_OFF)
    && (o_charge_supported[1] || o_charge_mode[1] == CHG_OFF)
    && (o_charge_supported[2] || o_charge_mode[2] == CHG_OFF)
    && (o_charge_supported[3] || o_charge_mode[3] == CHG_OFF))
    else $error("charge mode on unsupported port");
  a_reset_quiet: assert property (disable iff (1'b0) !i_resetn |=>
    o_port_power == 4'h0 && o_super_enable == 4'h0 && o_charge_supported == 4'h0 && o_charge_mode[0] == CHG_OFF)
    else $error("outputs active under reset");
endmodule : hub_ctrl_asserts

bind hub_port_power_charge_ctrl hub_ctrl_asserts #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ganged(i_ganged), .i_up_speed(i_up_speed),
  .i_up_connected(i_up_connected), .i_up_configured(i_up_configured), .i_power_request(i_power_request),
  .i_removal_ok(i_removal_ok), .i_overcurrent_n(i_overcurrent_n), .i_usb2_only(i_usb2_only),
  .i_power_charge_strap(i_power_charge_strap), .i_charge_policy(i_charge_policy), .o_port_power(o_port_power),
  .o_port_power_oe(o_port_power_oe), .o_super_enable(o_super_enable), .o_high_enable(o_high_enable),
  .o_charge_supported(o_charge_supported), .o_charge_mode(o_charge_mode));

/* verification/hub_switch_model.sv */
// Downstream power switches and strap resistors model
`timescale 1ns/1ps
module hub_switch_model (
  input  wire logic [3:0] i_port_power,
  input  wire logic [3:0] i_port_power_oe,
  input  wire logic [3:0] i_strap_level,
  input  wire logic [3:0] i_fault,
  output logic      [3:0] o_strap_pin,
  output logic      [3:0] o_overcurrent_n
);
  // Pin carries the device drive while enabled, else the strap resistor
  assign o_strap_pin     = (i_port_power_oe & i_port_power) | (~i_port_power_oe & i_strap_level);
  // Fault flag stays low as long as the switch is in fault
  assign o_overcurrent_n = ~i_fault;
endmodule : hub_switch_model

/* verification/hub_port_power_charge_ctrl_tb_top.sv */
// Self-checking bench of hub port power and charge control
`timescale 1ns/1ps
module hub_port_power_charge_ctrl_tb_top;
  import hub_ctrl_pkg::*;
  localparam int unsigned STEP = 8;
  logic           i_clk = 1'b0, i_resetn = 1'b0, ganged = 1'b0, conn = 1'b0, cfg = 1'b0;
  up_speed_e      speed = UP_SPEED_SUPER;
  charge_policy_e pol = POL_DEDICATED;
  logic [3:0]     req = 4'h0, rem = 4'h0, u2 = 4'h0, fault = 4'h0, strap = 4'h0, f;
  logic [3:0]     pin, oc_n, pwr, pwr_oe, sup_en, hi_en, chg_sup;
  charge_mode_e   mode [NUM_PORTS];
  int             failures = 0, cmp_count = 0, seed = 85103;
  // Clock of 10 ns period
  always #5 i_clk = ~i_clk;
  hub_port_power_charge_ctrl #(.STEP_CYCLES(STEP)) dut_u (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ganged(ganged), .i_up_speed(speed), .i_up_connected(conn),
    .i_up_configured(cfg), .i_power_request(req), .i_removal_ok(rem), .i_overcurrent_n(oc_n),
    .i_usb2_only(u2), .i_power_charge_strap(pin), .i_charge_policy(pol), .o_port_power(pwr),
    .o_port_power_oe(pwr_oe), .o_super_enable(sup_en), .o_high_enable(hi_en),
    .o_charge_supported(chg_sup), .o_charge_mode(mode));
  hub_switch_model sw_u (.i_port_power(pwr), .i_port_power_oe(pwr_oe), .i_strap_level(strap),
    .i_fault(fault), .o_strap_pin(pin), .o_overcurrent_n(oc_n));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Expected values from upstream speed, connection and policy
  function automatic logic [3:0] exp_super(up_speed_e s, logic [3:0] u);
    return (s == UP_SPEED_SUPER) ? ~u : 4'h0;
  endfunction : exp_super
  function automatic charge_mode_e exp_mode(logic c, logic s, charge_policy_e p);
    if (!s) return CHG_OFF;
    if (c) return host_charge_handshake_mode;
    case (p)
      POL_DIV_FIRST:  return divider_charge_mode_first;
      POL_DIV_SECOND: return divider_charge_mode_second;
      POL_DIV_THIRD:  return divider_charge_mode_third;
      POL_AUTO:       return divider_charge_mode_third;
      default:        return dedicated_charger_mode;
    endcase
  endfunction : exp_mode
  task automatic do_reset(input logic [3:0] s);
    @(posedge i_clk);
    i_resetn <= 1'b0;
    strap    <= s;
    tick(4);
    chk("power in reset", 8'h00, {pwr_oe, pwr});
    chk("speed in reset", 8'h00, {sup_en, hi_en});
    chk("support in reset", 8'h00, {1'b0, mode[0], chg_sup});
    @(posedge i_clk);
    i_resetn <= 1'b1;
    tick(10);
    chk("strap capture", {4'h0, s}, {4'h0, chg_sup});
    chk("pin enable", 8'h0f, {4'h0, pwr_oe});
  endtask : do_reset
  // Bounded wait for the next automatic charge step on port 0
  task automatic wait_mode(input charge_mode_e e, input int cyc);
    int n;
    n = 0;
    while (mode[0] !== e && n < 4 * STEP) begin
      tick(1);
      n++;
    end
    chk("auto step", {5'h0, e}, {5'h0, mode[0]});
    chk("auto step time", 8'(cyc), 8'(n));
    if (mode[0] !== e) results();
  endtask : wait_mode
  initial begin
    do_reset(4'($random(seed)) | 4'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk);
      speed <= up_speed_e'(i % 3);
      u2    <= (i == 0) ? 4'h0 : 4'($random(seed));
      tick(2);
      chk("super enable", {4'h0, exp_super(speed, u2)}, {4'h0, sup_en});
      chk("high enable", {4'h0, (speed == UP_SPEED_FULL) ? 4'h0 : 4'hf}, {4'h0, hi_en});
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      req <= (i == 0) ? 4'hf : 4'($random(seed));
      tick(2);
      chk("individual power", {4'h0, req}, {4'h0, pwr});
    end
    f = 4'h1 << ($random(seed) & 3);
    @(posedge i_clk);
    req   <= 4'hf;
    fault <= f;
    tick(6);
    chk("individual fault", {4'h0, ~f}, {4'h0, pwr});
    @(posedge i_clk);
    fault  <= 4'h0;
    ganged <= 1'b1;
    req    <= 4'h4;
    tick(6);
    chk("ganged on", 8'h0f, {4'h0, pwr});
    @(posedge i_clk);
    req <= 4'h0;
    rem <= 4'h7;
    tick(2);
    chk("ganged hold", 8'h0f, {4'h0, pwr});
    @(posedge i_clk);
    rem <= 4'hf;
    tick(2);
    chk("ganged off", 8'h00, {4'h0, pwr});
    @(posedge i_clk);
    req   <= 4'h1;
    fault <= 4'h8;
    tick(6);
    chk("ganged fault", 8'h00, {4'h0, pwr});
    @(posedge i_clk);
    fault  <= 4'h0;
    ganged <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      conn <= i[0];
      cfg  <= 1'($random(seed));
      pol  <= charge_policy_e'(i >> 1);
      tick(2);
      for (int p = 0; p < 4; p++) begin
        chk("charge mode", {5'h0, exp_mode(conn, strap[p], pol)}, {5'h0, mode[p]});
      end
    end
    @(posedge i_clk);
    conn <= 1'b0;
    pol  <= POL_AUTO;
    tick(2);
    chk("auto start", {5'h0, divider_charge_mode_third}, {5'h0, mode[0]});
    wait_mode(divider_charge_mode_second, STEP - 1);
    wait_mode(divider_charge_mode_first, STEP);
    wait_mode(dedicated_charger_mode, STEP);
    tick(4 * STEP);
    chk("auto final", {5'h0, dedicated_charger_mode}, {5'h0, mode[0]});
    @(posedge i_clk);
    conn <= 1'b1;
    tick(2);
    chk("auto left", {5'h0, host_charge_handshake_mode}, {5'h0, mode[0]});
    do_reset(4'($random(seed)) | 4'h1);
    results();
  end
endmodule : hub_port_power_charge_ctrl_tb_top
